// >>> logic/status_event_reporting.sv
`timescale 1ns/10ps

// ****************************************
// one status group: filters, mask, events
// ****************************************
module status_group #(
	parameter logic [15:0] DEFINED     = 16'hFFFF,
	parameter logic [15:0] PRESET_RISE = 16'hFFFF
) (
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	input  wire logic [15:0]            live,
	input  wire logic                   preset,
	input  wire logic                   wr_mask,
	input  wire logic                   wr_fall,
	input  wire logic                   wr_rise,
	input  wire logic [15:0]            wr_data,
	input  wire logic                   rd_event,
	output logic [15:0]                 live_m,
	output status_pkg::grp_regs_s       regs,
	output logic                        summary
);
	logic [15:0] mask_r;
	logic [15:0] fall_r;
	logic [15:0] rise_r;
	logic [15:0] event_r;
	logic [15:0] prev_r;
	logic [15:0] rise_seen;
	logic [15:0] fall_seen;
	logic [15:0] edge_hit;
	logic [15:0] prog_hit;
	logic [15:0] set_bits;

	// unused positions never reach the filters
	assign live_m = live & DEFINED;

	// last cycle's condition, the reference for edges
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			prev_r <= status_pkg::EVENT_RESET;
		end else begin
			prev_r <= live_m;
		end
	end

	// transition detect against the filters
	assign rise_seen = live_m & ~prev_r;
	assign fall_seen = ~live_m & prev_r;
	assign edge_hit  = (rise_seen & rise_r)
		| (fall_seen & fall_r);

	// a filter bit going to 1 counts over a condition already there for rise, already absent for fall
	always_comb begin
		prog_hit = 16'h0000;
		if (wr_rise) begin
			prog_hit = wr_data & ~rise_r & live_m;
		end else if (wr_fall) begin
			prog_hit = wr_data & ~fall_r & ~live_m & DEFINED;
		end
	end

	assign set_bits = (edge_hit | prog_hit) & mask_r;

	// mask register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mask_r <= status_pkg::MASK_RESET;
		end else if (preset) begin
			mask_r <= status_pkg::MASK_RESET;
		end else if (wr_mask) begin
			mask_r <= wr_data;
		end
	end

	// edge filters; preset outranks a write in the same cycle
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			fall_r <= status_pkg::FILTER_RESET;
			rise_r <= status_pkg::FILTER_RESET;
		end else if (preset) begin
			fall_r <= status_pkg::FILTER_RESET;
			rise_r <= PRESET_RISE;
		end else begin
			if (wr_fall) begin
				fall_r <= wr_data;
			end
			if (wr_rise) begin
				rise_r <= wr_data;
			end
		end
	end

	// sticky events: a new set wins over the read clear
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			event_r <= status_pkg::EVENT_RESET;
		end else if (rd_event) begin
			event_r <= set_bits;
		end else begin
			event_r <= event_r | set_bits;
		end
	end

	// summary follows registers only, so it is glitch free
	assign summary = |(event_r & mask_r);

	// one driver for the whole carrier, never one per member
	assign regs = '{mask: mask_r, fall: fall_r, rise: rise_r, events: event_r};

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	rise_latch_a: assert property (
		(|(rise_seen & rise_r & mask_r))
		|=> ((event_r & $past(rise_seen & rise_r & mask_r))
			== $past(rise_seen & rise_r & mask_r)))
		else $error("rising edge not latched");

	fall_latch_a: assert property (
		(|(fall_seen & fall_r & mask_r))
		|=> ((event_r & $past(fall_seen & fall_r & mask_r))
			== $past(fall_seen & fall_r & mask_r)))
		else $error("falling edge not latched");

	no_cause_a: assert property (
		1'b1 |=> ((event_r & ~$past(event_r) & ~$past(set_bits)) == 16'h0000))
		else $error("event set without a cause");

	unmasked_quiet_a: assert property (
		(!rd_event && ((edge_hit | prog_hit) & ~mask_r) != 16'h0000)
		|=> ((event_r & ~$past(event_r) & $past(~mask_r)) == 16'h0000))
		else $error("masked bit reached events");

	read_clear_a: assert property (
		rd_event && set_bits == 16'h0000 |=> event_r == 16'h0000)
		else $error("event read did not clear");

	set_wins_a: assert property (
		rd_event && set_bits != 16'h0000 |=> event_r == $past(set_bits))
		else $error("event lost on clearing read");

	prog_set_a: assert property (
		wr_rise && !preset && ((wr_data & ~rise_r & live_m & mask_r) != 16'h0000)
		|=> ((event_r & $past(wr_data & live_m & mask_r & ~rise_r))
			== $past(wr_data & live_m & mask_r & ~rise_r)))
		else $error("filter write did not set event");

	prog_fall_a: assert property (
		wr_fall && ((wr_data & ~fall_r & ~live_m & DEFINED & mask_r) != 16'h0000)
		|=> ((event_r & $past(wr_data & ~live_m & DEFINED & mask_r & ~fall_r))
			== $past(wr_data & ~live_m & DEFINED & mask_r & ~fall_r)))
		else $error("falling filter write did not set event");

	preset_load_a: assert property (
		preset |=> mask_r == 16'h0000 && fall_r == 16'h0000
			&& rise_r == PRESET_RISE)
		else $error("preset values wrong");

	mask_hold_a: assert property (
		!wr_mask && !preset |=> $stable(mask_r))
		else $error("mask changed without write");

	mask_write_a: assert property (
		wr_mask && !preset |=> mask_r == $past(wr_data))
		else $error("mask write lost");

	prev_track_a: assert property (
		1'b1 |=> prev_r == $past(live_m))
		else $error("previous condition stale");

	summary_rise_a: assert property (
		$rose(summary) |-> $past(set_bits != 16'h0000) || $past(wr_mask))
		else $error("summary rose without cause");

	read_clear_c: cover property (rd_event && set_bits != 16'h0000);
	both_edge_c: cover property (|(fall_seen & fall_r & rise_r & mask_r));
	prog_hit_c: cover property (|(prog_hit & mask_r));
	preset_c: cover property (preset ##1 summary == 1'b0);

endmodule : status_group

// ****************************************
// top: host command port and two groups
// ****************************************
module status_event_reporting (
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	input  wire logic                   cmd_valid,
	input  status_pkg::cmd_s            cmd,
	input  wire logic [15:0]            oper_live,
	input  wire logic [15:0]            ques_live,
	output logic                        rsp_valid_r,
	output logic [15:0]                 rsp_data_r,
	output logic [7:0]                  summary_bits
);
	logic                  preset;
	logic                  wr_any;
	logic                  rd_any;
	logic [1:0]            wr_mask;
	logic [1:0]            wr_fall;
	logic [1:0]            wr_rise;
	logic [1:0]            rd_event;
	logic [1:0]            grp_sel;
	logic [15:0]           live_m [2];
	status_pkg::grp_regs_s regs [2];
	logic [1:0]            summary;
	logic [15:0]           rdata;
	status_pkg::grp_regs_s pick;

	// command decode; preset ignores the group bit
	assign preset  = cmd_valid && cmd.sel == status_pkg::SEL_PRESET;
	assign wr_any  = cmd_valid && cmd.write;
	assign rd_any  = cmd_valid && !cmd.write && !preset;
	assign grp_sel = cmd.ques ? 2'b10 : 2'b01;
	assign wr_mask = (wr_any && cmd.sel == status_pkg::SEL_MASK) ? grp_sel : 2'b00;
	assign wr_fall = (wr_any && cmd.sel == status_pkg::SEL_FALL) ? grp_sel : 2'b00;
	assign wr_rise = (wr_any && cmd.sel == status_pkg::SEL_RISE) ? grp_sel : 2'b00;
	// the read that returns events is also the one that clears them
	assign rd_event = (rd_any && cmd.sel == status_pkg::SEL_EVENT) ? grp_sel : 2'b00;

	status_group #(
		.DEFINED     (status_pkg::OPER_DEFINED),
		.PRESET_RISE (status_pkg::OPER_PRESET_RISE)
	) oper_grp (
		.core_clk (core_clk),
		.reset    (reset),
		.live     (oper_live),
		.preset   (preset),
		.wr_mask  (wr_mask[0]),
		.wr_fall  (wr_fall[0]),
		.wr_rise  (wr_rise[0]),
		.wr_data  (cmd.data),
		.rd_event (rd_event[0]),
		.live_m   (live_m[0]),
		.regs     (regs[0]),
		.summary  (summary[0])
	);

	status_group #(
		.DEFINED     (status_pkg::QUES_DEFINED),
		.PRESET_RISE (status_pkg::QUES_PRESET_RISE)
	) ques_grp (
		.core_clk (core_clk),
		.reset    (reset),
		.live     (ques_live),
		.preset   (preset),
		.wr_mask  (wr_mask[1]),
		.wr_fall  (wr_fall[1]),
		.wr_rise  (wr_rise[1]),
		.wr_data  (cmd.data),
		.rd_event (rd_event[1]),
		.live_m   (live_m[1]),
		.regs     (regs[1]),
		.summary  (summary[1])
	);

	// read mux; live state is sampled, never stored
	always_comb begin
		pick = cmd.ques ? regs[1] : regs[0];
		case (cmd.sel)
			status_pkg::SEL_LIVE:  rdata = cmd.ques ? live_m[1] : live_m[0];
			status_pkg::SEL_MASK:  rdata = pick.mask;
			status_pkg::SEL_EVENT: rdata = pick.events;
			status_pkg::SEL_FALL:  rdata = pick.fall;
			status_pkg::SEL_RISE:  rdata = pick.rise;
			default:               rdata = 16'h0000;
		endcase
	end

	// answer one cycle after the query
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= 16'h0000;
		end else begin
			rsp_valid_r <= rd_any;
			if (rd_any) begin
				rsp_data_r <= rdata;
			end
		end
	end

	// status byte view: only the two summary positions are ours
	always_comb begin
		summary_bits = 8'h00;
		summary_bits[status_pkg::OPER_SUM_BIT] = summary[0];
		summary_bits[status_pkg::QUES_SUM_BIT] = summary[1];
	end

	default clocking tcb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	live_read_a: assert property (
		rd_any && cmd.sel == status_pkg::SEL_LIVE
		|=> rsp_valid_r && rsp_data_r == $past(rdata)
			&& ((rsp_data_r & ~$past(cmd.ques ? status_pkg::QUES_DEFINED
				: status_pkg::OPER_DEFINED)) == 16'h0000))
		else $error("live read wrong");

	event_read_a: assert property (
		rd_any && cmd.sel == status_pkg::SEL_EVENT
		|=> rsp_data_r == $past(pick.events))
		else $error("event read value wrong");

	live_read_c: cover property (rd_any && cmd.sel == status_pkg::SEL_LIVE && cmd.ques);

endmodule : status_event_reporting

// >>> logic/status_pkg.sv
package status_pkg;

	// ****************************************
	// widths and status byte positions
	// ****************************************
	localparam int unsigned REG_W        = 16;
	localparam int unsigned OPER_SUM_BIT = 7;
	localparam int unsigned QUES_SUM_BIT = 3;

	// ****************************************
	// condition bit weights
	// ****************************************
	localparam logic [15:0] CONSTANT_CURRENT_MODE = 16'h0400;
	localparam logic [15:0] CONSTANT_VOLTAGE_MODE = 16'h0100;
	localparam logic [15:0] TRIGGER_WAIT          = 16'h0020;
	localparam logic [15:0] HIGH_VOLTAGE_TRIP     = 16'h0001;
	localparam logic [15:0] CURRENT_LIMIT_TRIP    = 16'h0002;
	localparam logic [15:0] THERMAL_FAULT         = 16'h0010;
	localparam logic [15:0] OUTPUT_DISABLE_INPUT  = 16'h0200;
	localparam logic [15:0] REGULATION_LOST       = 16'h0400;

	// every other position is a reserved_bit and reads zero in live and event reads
	localparam logic [15:0] OPER_DEFINED = CONSTANT_CURRENT_MODE
		| CONSTANT_VOLTAGE_MODE | TRIGGER_WAIT;
	localparam logic [15:0] QUES_DEFINED = HIGH_VOLTAGE_TRIP
		| CURRENT_LIMIT_TRIP | THERMAL_FAULT
		| OUTPUT_DISABLE_INPUT | REGULATION_LOST;

	// ****************************************
	// reset and status_preset values
	// ****************************************
	localparam logic [15:0] MASK_RESET       = 16'h0000;
	localparam logic [15:0] FILTER_RESET     = 16'h0000;
	localparam logic [15:0] EVENT_RESET      = 16'h0000;
	localparam logic [15:0] OPER_PRESET_RISE = 16'h0521; // 1313 decimal
	localparam logic [15:0] QUES_PRESET_RISE = 16'h0613; // 1555 decimal

	// ****************************************
	// host command carrier
	// ****************************************
	typedef enum logic [2:0] {
		SEL_LIVE   = 3'b000,
		SEL_MASK   = 3'b001,
		SEL_EVENT  = 3'b010,
		SEL_FALL   = 3'b011,
		SEL_RISE   = 3'b100,
		SEL_PRESET = 3'b101
	} reg_sel_e;

	typedef struct packed {
		logic        ques;
		reg_sel_e    sel;
		logic        write;
		logic [15:0] data;
	} cmd_s;

	typedef struct packed {
		logic [15:0] mask;
		logic [15:0] fall;
		logic [15:0] rise;
		logic [15:0] events;
	} grp_regs_s;

endpackage : status_pkg

// >>> dv/host_model.sv
`timescale 1ns/10ps

// ****************************************
// remote host: issues status commands
// ****************************************
module host_model (
	input  wire logic        core_clk,
	input  wire logic        rsp_valid_r,
	input  wire logic [15:0] rsp_data_r,
	output logic             cmd_valid,
	output status_pkg::cmd_s cmd
);

	// idle from time zero so the command port never floats
	initial begin
		cmd_valid = 1'b0;
		cmd       = '0;
	end

	// one command held across a single taking edge
	task automatic send(input logic q, input status_pkg::reg_sel_e s, input logic w,
		input logic [15:0] d);
		@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd       = '{ques: q, sel: s, write: w, data: d};
		@(negedge core_clk);
		cmd_valid = 1'b0;
		cmd.data  = ~d; // stale data must not be trusted once idle
	endtask : send

	// read; the answer wait is bounded so a dead port cannot hang the run
	task automatic query(input logic q, input status_pkg::reg_sel_e s,
		output logic [15:0] d, output logic ok);
		int i;
		ok = 1'b0;
		d  = 16'h0000;
		send(q, s, 1'b0, 16'h0000);
		for (i = 0; i < 4 && !ok; i++) begin
			if (rsp_valid_r === 1'b1) begin
				ok = 1'b1;
				d  = rsp_data_r;
			end else begin
				@(negedge core_clk);
			end
		end
	endtask : query

endmodule : host_model

// >>> dv/status_event_reporting_bench.sv
`timescale 1ns/10ps

// ****************************************
// bench: command sequences with expected values
// ****************************************
module status_event_reporting_bench;
	logic             core_clk;
	logic             reset;
	logic             cmd_valid;
	logic             rsp_valid_r;
	status_pkg::cmd_s cmd;
	logic [15:0]      oper_live;
	logic [15:0]      ques_live;
	logic [15:0]      rsp_data_r;
	logic [15:0]      val;
	logic [7:0]       summary_bits;
	logic             ok;
	int               err_total;
	int               total_checks;
	int               i;

	status_event_reporting status_event_reporting_inst (
		.core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
		.oper_live(oper_live), .ques_live(ques_live), .rsp_valid_r(rsp_valid_r),
		.rsp_data_r(rsp_data_r), .summary_bits(summary_bits));

	host_model host_model_inst (
		.core_clk(core_clk), .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r),
		.cmd_valid(cmd_valid), .cmd(cmd));

	// 200 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	task automatic wr(input logic q, input status_pkg::reg_sel_e s, input logic [15:0] d);
		host_model_inst.send(q, s, 1'b1, d);
	endtask : wr

	// a missing answer counts as a mismatch and ends the run
	task automatic rd(input logic q, input status_pkg::reg_sel_e s, input logic [15:0] exp);
		host_model_inst.query(q, s, val, ok);
		if (!ok) begin
			err_total++;
			report_and_stop();
		end else begin
			check(val, exp);
		end
	endtask : rd

	// live change lands, then one more edge lets any event latch
	task automatic live(input logic [15:0] o, input logic [15:0] q);
		@(negedge core_clk);
		oper_live = o;
		ques_live = q;
		@(negedge core_clk);
	endtask : live

	task automatic sum(input logic [7:0] exp);
		check({8'h00, summary_bits}, {8'h00, exp});
	endtask : sum

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		err_total    = 0;
		total_checks = 0;
		oper_live    = 16'h0000;
		ques_live    = 16'h0000;
		reset        = 1'b1;
		repeat (12) @(negedge core_clk);
		reset = 1'b0;
		// mask, event and both filters of each group, and the summary byte, start cleared
		for (i = 1; i < 5; i++) begin
			rd(1'b0, status_pkg::reg_sel_e'(i), 16'h0000);
			rd(1'b1, status_pkg::reg_sel_e'(i), 16'h0000);
		end
		sum(8'h00);
		// live reads show only defined positions, unlatched
		live(16'hFFFF, 16'hFFFF);
		rd(1'b0, status_pkg::SEL_LIVE, status_pkg::OPER_DEFINED);
		rd(1'b1, status_pkg::SEL_LIVE, status_pkg::QUES_DEFINED);
		rd(1'b1, status_pkg::reg_sel_e'(3'h6), 16'h0000);
		live(16'h0000, 16'h0000);
		// operation group: mask, filters, edges
		wr(1'b0, status_pkg::SEL_MASK, 16'h0520);
		rd(1'b0, status_pkg::SEL_MASK, 16'h0520);
		live(16'h0520, 16'h0000);
		rd(1'b0, status_pkg::SEL_EVENT, 16'h0000);
		wr(1'b0, status_pkg::SEL_RISE, 16'h0020);
		sum(8'h80);
		rd(1'b0, status_pkg::SEL_EVENT, 16'h0020);
		rd(1'b0, status_pkg::SEL_EVENT, 16'h0000);
		sum(8'h00);
		wr(1'b0, status_pkg::SEL_FALL, 16'h0500);
		wr(1'b0, status_pkg::SEL_RISE, 16'h0420);
		rd(1'b0, status_pkg::SEL_EVENT, 16'h0400);
		live(16'h0020, 16'h0000);
		rd(1'b0, status_pkg::SEL_EVENT, 16'h0500);
		live(16'h0420, 16'h0000);
		wr(1'b0, status_pkg::SEL_MASK, 16'h0000);
		sum(8'h00);
		rd(1'b0, status_pkg::SEL_EVENT, 16'h0400);
		live(16'h0000, 16'h0000);
		rd(1'b0, status_pkg::SEL_EVENT, 16'h0000);
		// falling filter armed over a condition already low
		wr(1'b0, status_pkg::SEL_MASK, 16'h0100);
		wr(1'b0, status_pkg::SEL_FALL, 16'h0000);
		wr(1'b0, status_pkg::SEL_FALL, 16'h0100);
		rd(1'b0, status_pkg::SEL_EVENT, 16'h0100);
		// questionable group
		wr(1'b1, status_pkg::SEL_MASK, 16'h0010);
		wr(1'b1, status_pkg::SEL_RISE, 16'h0010);
		live(16'h0000, 16'h0010);
		sum(8'h08);
		rd(1'b1, status_pkg::SEL_EVENT, 16'h0010);
		rd(1'b1, status_pkg::SEL_EVENT, 16'h0000);
		live(16'h0000, 16'h0000);
		// event arriving on the edge that takes the clearing read
		fork
			rd(1'b1, status_pkg::SEL_EVENT, 16'h0000);
			begin
				@(negedge core_clk);
				ques_live = 16'h0010;
			end
		join
		rd(1'b1, status_pkg::SEL_EVENT, 16'h0010);
		// preset reloads filters and masks in both groups
		wr(1'b0, status_pkg::SEL_PRESET, 16'h0000);
		rd(1'b0, status_pkg::SEL_RISE, status_pkg::OPER_PRESET_RISE);
		rd(1'b1, status_pkg::SEL_RISE, status_pkg::QUES_PRESET_RISE);
		for (i = 0; i < 2; i++) begin
			rd(i[0], status_pkg::SEL_MASK, 16'h0000);
			rd(i[0], status_pkg::SEL_FALL, 16'h0000);
		end
		// the event register ignores host writes
		wr(1'b0, status_pkg::SEL_EVENT, 16'hFFFF);
		rd(1'b0, status_pkg::SEL_EVENT, 16'h0000);
		// a mid-run reset returns the masks to zero
		wr(1'b1, status_pkg::SEL_MASK, 16'h0613);
		rd(1'b1, status_pkg::SEL_MASK, 16'h0613);
		@(negedge core_clk);
		reset = 1'b1;
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		rd(1'b1, status_pkg::SEL_MASK, 16'h0000);
		rd(1'b1, status_pkg::SEL_RISE, 16'h0000);
		sum(8'h00);
		report_and_stop();
	end

endmodule : status_event_reporting_bench
